// >>> design/offset_filter_consts.vh
/*
  constants of the offset trim and offset filter block: register indices,
  field positions, reset values and counts; assumes nothing but inclusion.
*/
`ifndef OFFSET_FILTER_CONSTS_VH
`define OFFSET_FILTER_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_TRIM_B       12'h094
`define IDX_FILT_CTRL0   12'h097
`define IDX_FILT_CTRL1   12'h098
`define IDX_CAL_CTRL     12'h0A0
`define IDX_STATUS       12'h0A1

// register select codes
`define SEL_NONE         3'h0
`define SEL_TRIM         3'h1
`define SEL_CTRL0        3'h2
`define SEL_CTRL1        3'h3
`define SEL_CAL          3'h4
`define SEL_STAT         3'h5

// reset values
`define RST_CTRL0        8'h00
`define RST_CTRL1        8'h33
`define RST_CAL          4'h0
`define RST_TRIM_RSVD    4'h0

// field positions
`define F_KEEP_LOW       0
`define F_BW_HI          7
`define F_BW_LO          4
`define F_SOAK_HI        3
`define F_SOAK_LO        0
`define F_TRIM_HI        11
`define F_OFFSET_CAL_ENABLE         0
`define F_BACKGROUND_CAL_ENABLE         1
`define F_BACKGROUND_OFFSET_CAL_ENABLE       2
`define F_FILT_EN        3

// filter coefficient codes and shift
`define BW_CODE_MIN      4'h1
`define BW_CODE_MAX      4'h5
`define BW_SHIFT_BASE    4'h9
`define FRAC_BITS        16
`define TRIM_MID         13'h0800

// bus answers
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

// fifo
`define FIFO_DEPTH       32
`define FIFO_AW          5
`define STREAM_W         15

`endif

// >>> design/sample_fifo.v
/*
  synchronous fifo of parameter width and depth with valid/ready on both
  sides; assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter WIDTH = 15,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output reg  [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // storage
  reg [AW-1:0]    wrPtr;            // next slot to fill
  reg [AW-1:0]    rdPtr;            // next slot to drain
  reg [AW:0]      count;            // words held
  reg             outFull;          // output register holds a word
  wire            push;
  wire            pop;
  wire            memEmpty;

  assign inReady  = (count != DEPTH[AW:0]);    // honest full
  assign push     = inValid && inReady;
  assign memEmpty = (count == {(AW+1){1'b0}});
  // refill output register when it is empty or being taken
  assign pop      = !memEmpty && (!outFull || outReady);
  assign outValid = outFull;

  // pointer, count and output register
  always @(posedge ref_clk) begin
    if (rst) begin
      wrPtr   <= {AW{1'b0}};
      rdPtr   <= {AW{1'b0}};
      count   <= {(AW+1){1'b0}};
      outFull <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wrPtr] <= inData;
        wrPtr      <= wrPtr + 1'b1;
      end
      if (pop) begin
        outData <= mem[rdPtr];
        rdPtr   <= rdPtr + 1'b1;
        outFull <= 1'b1;
      end else if (outReady) begin
        outFull <= 1'b0;
      end
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // sample_fifo
`default_nettype wire

// >>> design/bank_offset_iir.v
/*
  per-bank first-order offset estimators plus one all-bank estimator;
  assumes samples are signed and arrive with a valid bank index.
*/
`timescale 1ns/10ps
`default_nettype none
`include "offset_filter_consts.vh"
module bank_offset_iir (
  input  wire               ref_clk,
  input  wire               rst,
  input  wire               update,
  input  wire [2:0]         bank,
  input  wire signed [11:0] sample,
  input  wire [3:0]         shift,
  input  wire               keepLow,
  input  wire               enable,
  output wire signed [11:0] corr
);
  reg signed [27:0] est [0:7];  // per-bank running offset, 16 fraction bits
  reg signed [27:0] glob;       // common offset of all banks
  wire signed [27:0] diff;
  integer i;

  // one accumulator step: e += (x - e) >>> sh
  function signed [27:0] stepIir;
    input signed [27:0] e;
    input signed [11:0] x;
    input [3:0]         sh;
    reg signed [28:0]   d;  // one guard bit so the difference cannot wrap
    reg signed [28:0]   s;
    begin
      d       = $signed({x[11], x, 16'h0000}) - e;
      s       = d >>> sh;
      stepIir = e + s[27:0];
    end
  endfunction

  // keep low content: remove only the bank's deviation from the common value
  assign diff = keepLow ? (est[bank] - glob) : est[bank];
  assign corr = enable ? diff[27:16] : 12'h000;

  // estimator update on each accepted sample while enabled
  always @(posedge ref_clk) begin
    if (rst) begin
      for (i = 0; i < 8; i = i + 1)
        est[i] <= 28'h000_0000;
      glob <= 28'h000_0000;
    end else if (update && enable) begin
      est[bank] <= stepIir(est[bank], sample, shift);
      glob      <= stepIir(glob, sample, shift);
    end
  end
endmodule // bank_offset_iir
`default_nettype wire

// >>> design/adc_offset_trim_and_filter.v
/*
  offset trim for the second converter core and a bank offset filter for samples of both cores, with
  an axi4-lite register slave and an output fifo; assumes samples and bus
  are synchronous to ref_clk and the calibration engine sits outside.
*/
// Design decision made here: register access over AXI4-Lite.
// Overview of operation
// - trim word applied on second core, second input
// - trim loads factory value at reset, rewritable
// - trim bits 15-12 reserved, writable, reset zero
// - keep-low set: remove only bank mismatch
// - keep-low clear: remove all offsets, DC too
// - bandwidth codes 1-5 pick shift 10-14
// - settle code, bits 3-0, resets to 3
// - settling only with filter and background enabled
// - after settling core returns online, filter in path
// - control0 bits 7-1 reserved, writable, reset zero
`timescale 1ns/10ps
`default_nettype none
`include "offset_filter_consts.vh"
module adc_offset_trim_and_filter #(
  parameter SETTLE_UNIT = 1024  // cycles per settle step, shorten in simulation
) (
  input  wire        ref_clk,
  input  wire        rst,
  // axi4-lite slave
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // calibration engine
  input  wire [11:0] factoryTrim,
  input  wire        foregroundCalComplete,
  input  wire        calHaltedFlag,
  input  wire        coreCalibrated,
  // sample stream in
  input  wire [11:0] sampleData,
  input  wire [2:0]  sampleBank,
  input  wire        sampleCoreB,
  input  wire        sampleInputB,
  input  wire        sampleValid,
  output wire        sampleReady,
  // corrected stream out
  output wire [11:0] outData,
  output wire [2:0]  outBank,
  output wire        outValid,
  input  wire        outReady,
  output reg         coreOnline
);
  localparam ST_ONLINE = 1'b0;  // core in service
  localparam ST_SETTLE = 1'b1;  // filter soaking, core offline

  reg  [7:0]  ctrl0;            // keep-low and reserved bits
  reg  [7:0]  ctrl1;            // bandwidth and settle codes
  reg  [15:0] trim;             // trim word plus reserved nibble
  reg  [3:0]  calCtrl;          // calibration enables
  reg         settleDoneSeen;   // sticky: a settle period ended
  reg         state;            // settle state
  reg  [31:0] settleCnt;        // cycles left in settle
  reg         awHeld;           // write address taken
  reg  [11:0] awIdx;            // its register index
  reg         wHeld;            // write data taken
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg  [11:0] pipeData;         // corrected sample awaiting fifo
  reg  [2:0]  pipeBank;
  reg         pipeValid;
  wire        fifoInReady;
  wire [14:0] fifoOut;
  wire        doWrite;
  wire [2:0]  wSel;
  wire [2:0]  rSel;
  wire        take;
  wire signed [11:0] trimmed;
  wire signed [11:0] corr;
  wire [3:0]  bwCode;
  wire        bwLegal;
  wire        filtEn;
  wire        settleArm;
  wire [31:0] settleLen;

  // map a byte address to a register select
  function [2:0] regSel;
    input [31:0] addr;
    begin
      if (addr[1:0] != 2'b00 || addr[31:14] != 18'h0_0000)
        regSel = `SEL_NONE;
      else case (addr[13:2])
        `IDX_TRIM_B:     regSel = `SEL_TRIM;
        `IDX_FILT_CTRL0: regSel = `SEL_CTRL0;
        `IDX_FILT_CTRL1: regSel = `SEL_CTRL1;
        `IDX_CAL_CTRL:   regSel = `SEL_CAL;
        `IDX_STATUS:     regSel = `SEL_STAT;
        default:         regSel = `SEL_NONE;
      endcase
    end
  endfunction

  // byte-lane merge of write data into an old word
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer k;
    begin
      laneMerge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          laneMerge[k*8 +: 8] = data[k*8 +: 8];
    end
  endfunction

  // saturate a 13-bit signed value into 12 bits
  function signed [11:0] sat12;
    input signed [12:0] v;
    begin
      if (v > 13'sh07FF)
        sat12 = 12'sh7FF;
      else if (v < -13'sh0800)
        sat12 = 12'sh800;
      else
        sat12 = v[11:0];
    end
  endfunction

  // bus handshakes: one write and one read in flight
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
  assign wSel          = regSel({18'h0_0000, awIdx, 2'b00});
  assign rSel          = regSel(s_axi_araddr);
  wire [31:0] mergeTrim  = laneMerge({16'h0000, trim}, wData, wStrb);      // cut to 16 bits at the write
  wire [31:0] mergeCtrl0 = laneMerge({24'h00_0000, ctrl0}, wData, wStrb);  // cut to 8 bits at the write
  wire [31:0] mergeCtrl1 = laneMerge({24'h00_0000, ctrl1}, wData, wStrb);  // cut to 8 bits at the write

  // write address and data capture, response
  always @(posedge ref_clk) begin
    if (rst) begin
      awHeld       <= 1'b0;
      awIdx        <= 12'h000;
      wHeld        <= 1'b0;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        // misaligned or out-of-range addresses map to an unused index
        awIdx  <= (regSel(s_axi_awaddr) == `SEL_NONE) ? 12'hFFF : s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wSel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file; trim writes are not blocked, software keeps off them
  // during calibration
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl0   <= `RST_CTRL0;
      ctrl1   <= `RST_CTRL1;
      trim    <= {`RST_TRIM_RSVD, factoryTrim};
      calCtrl <= `RST_CAL;
    end else if (doWrite) begin
      case (wSel)
        `SEL_TRIM:  trim    <= mergeTrim[15:0];
        `SEL_CTRL0: ctrl0   <= mergeCtrl0[7:0];
        `SEL_CTRL1: ctrl1   <= mergeCtrl1[7:0];
        `SEL_CAL:   calCtrl <= wStrb[0] ? wData[3:0] : calCtrl;
        default:    ctrl0   <= ctrl0;
      endcase
    end
  end

  // read channel; status shows calibration flags for the read rules
  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (rSel)
        `SEL_TRIM:  s_axi_rdata <= {16'h0000, trim};
        `SEL_CTRL0: s_axi_rdata <= {24'h00_0000, ctrl0};
        `SEL_CTRL1: s_axi_rdata <= {24'h00_0000, ctrl1};
        `SEL_CAL:   s_axi_rdata <= {28'h000_0000, calCtrl};
        `SEL_STAT:  s_axi_rdata <= {27'h000_0000, settleDoneSeen, state, coreOnline,
                                    calHaltedFlag, foregroundCalComplete};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // trim applied only on second core sampling second input
  assign trimmed = (sampleCoreB && sampleInputB)
                 ? sat12($signed({~sampleData[11], ~sampleData[11], sampleData[10:0]}) + $signed({1'b0, trim[11:0]})
                         - $signed(`TRIM_MID))
                 : $signed({~sampleData[11], sampleData[10:0]});

  // reserved bandwidth codes freeze the estimators
  assign bwCode  = ctrl1[`F_BW_HI:`F_BW_LO];
  assign bwLegal = (bwCode >= `BW_CODE_MIN) && (bwCode <= `BW_CODE_MAX);
  assign filtEn  = calCtrl[`F_FILT_EN] && bwLegal;
  assign take    = sampleValid && sampleReady;
  // a stall at the fifo stops the input as well
  assign sampleReady = !pipeValid || fifoInReady;

  bank_offset_iir iir (
    .ref_clk (ref_clk),
    .rst     (rst),
    .update  (take),
    .bank    (sampleBank),
    .sample  (trimmed),
    .shift   (bwCode + `BW_SHIFT_BASE),
    .keepLow (ctrl0[`F_KEEP_LOW]),
    .enable  (filtEn),
    .corr    (corr)
  );

  // pipeline register into the fifo; offline core pushes nothing
  always @(posedge ref_clk) begin
    if (rst) begin
      pipeValid <= 1'b0;
      pipeData  <= 12'h000;
      pipeBank  <= 3'h0;
    end else if (sampleReady) begin
      pipeValid <= take && (state == ST_ONLINE);
      pipeData  <= sat12($signed({trimmed[11], trimmed}) - $signed({corr[11], corr}));
      pipeBank  <= sampleBank;
    end
  end

  sample_fifo #(
    .WIDTH (`STREAM_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) outFifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inData   ({pipeBank, pipeData}),
    .inValid  (pipeValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (outValid),
    .outReady (outReady)
  );
  assign outData = fifoOut[11:0];
  assign outBank = fifoOut[14:12];

  // settle applies with filtering and background calibration both on
  assign settleArm = coreCalibrated && calCtrl[`F_FILT_EN] && calCtrl[`F_BACKGROUND_CAL_ENABLE];
  assign settleLen = SETTLE_UNIT << ctrl1[`F_SOAK_HI:`F_SOAK_LO];

  // settle state machine; sticky done flag, set beats clear
  always @(posedge ref_clk) begin
    if (rst) begin
      state          <= ST_ONLINE;
      settleCnt      <= 32'h0000_0000;
      coreOnline     <= 1'b1;
      settleDoneSeen <= 1'b0;
    end else begin
      if (doWrite && wSel == `SEL_STAT && wStrb[0] && wData[4])
        settleDoneSeen <= 1'b0;
      case (state)
        ST_ONLINE: begin
          if (settleArm) begin
            state      <= ST_SETTLE;
            settleCnt  <= settleLen - 32'h0000_0001;
            coreOnline <= 1'b0;
          end
        end
        ST_SETTLE: begin
          if (settleArm) begin
            settleCnt <= settleLen - 32'h0000_0001;
          end else if (settleCnt == 32'h0000_0000) begin
            state          <= ST_ONLINE;
            coreOnline     <= 1'b1;
            settleDoneSeen <= 1'b1;
          end else begin
            settleCnt <= settleCnt - 32'h0000_0001;
          end
        end
        default: begin
          state      <= ST_ONLINE;
          coreOnline <= 1'b1;
        end
      endcase
    end
  end
endmodule // adc_offset_trim_and_filter
`default_nettype wire

// >>> testbench/adc_offset_trim_and_filter_properties.sv
/*
  port-level checker for the offset trim and filter block;
  assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_offset_trim_and_filter_properties #(
  parameter SETTLE_UNIT = 1024
) (
  input wire        ref_clk,
  input wire        rst,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        coreCalibrated,
  input wire        sampleReady,
  input wire [11:0] outData,
  input wire [2:0]  outBank,
  input wire        outValid,
  input wire        outReady,
  input wire        coreOnline
);
  localparam int MAXLOW = SETTLE_UNIT * 32768;  // longest settle code 15
  int lowCnt;  // cycles spent offline
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // offline run length, cleared whenever the core is in service
  always @(posedge ref_clk) begin
    lowCnt <= (rst || coreOnline) ? 0 : lowCnt + 1;
  end
  sequence s_readTaken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_dropped; $fell(coreOnline); endsequence
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_rLatency; s_readTaken |=> s_axi_rvalid; endproperty
  property p_wRefuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_outHold; outValid && !outReady |=> outValid && $stable(outData) && $stable(outBank); endproperty
  property p_fullRefuse; !sampleReady |-> outValid; endproperty
  property p_offCause; s_dropped |-> $past(coreCalibrated); endproperty
  property p_settleMin; $rose(coreOnline) |-> lowCnt >= SETTLE_UNIT; endproperty
  property p_settleMax; lowCnt <= MAXLOW; endproperty
  a_bHold: assert property (p_bHold) else $error("bvalid or bresp moved before bready");
  a_rHold: assert property (p_rHold) else $error("rvalid or rdata moved before rready");
  a_rLatency: assert property (p_rLatency) else $error("read answer late");
  a_wRefuse: assert property (p_wRefuse) else $error("write taken while response pending");
  a_outHold: assert property (p_outHold) else $error("output word moved while stalled");
  a_fullRefuse: assert property (p_fullRefuse) else $error("input refused with empty output");
  a_offCause: assert property (p_offCause) else $error("core went offline without calibration");
  a_settleMin: assert property (p_settleMin) else $error("settle shorter than one step");
  a_settleMax: assert property (p_settleMax) else $error("core never returned online");
endmodule // adc_offset_trim_and_filter_properties
`default_nettype wire

// >>> testbench/adc_offset_trim_and_filter_tb.sv
/*
  self-checking bench for the offset trim and filter block;
  assumes the design header is on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "offset_filter_consts.vh"
module adc_offset_trim_and_filter_tb;
  localparam int UNIT = 4;  // short settle step keeps the run brief
  logic        ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, bw;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [11:0] factoryTrim, sampleData, outData;
  logic [2:0]  sampleBank, outBank;
  logic        foregroundCalComplete, calHaltedFlag, coreCalibrated, sampleCoreB, sampleInputB;
  logic        sampleValid, sampleReady, outValid, outReady, coreOnline, keep, filt, stall, tk;
  logic [15:0] trim;            // bench copy of the trim register
  logic signed [27:0] est[8];   // bench copy of bank estimates
  logic signed [27:0] glob;     // bench copy of the all-bank estimate
  logic [11:0] expq[$];         // expected corrected words in order
  int          mismatches, checks_done, cycles, n;
  adc_offset_trim_and_filter #(.SETTLE_UNIT(UNIT)) dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .factoryTrim, .foregroundCalComplete, .calHaltedFlag, .coreCalibrated, .sampleData,
    .sampleBank, .sampleCoreB, .sampleInputB, .sampleValid, .sampleReady, .outData, .outBank, .outValid,
    .outReady, .coreOnline);
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end
  // far side takes words at random unless stalled for the fill test
  always @(posedge ref_clk) begin
    outReady <= !stall && ($urandom % 4 != 0);
    if (outValid === 1'b1 && outReady === 1'b1) begin
      if (expq.size() == 0) chk("extraWord", 1, 0);
      else chk("outData", outData, expq.pop_front());
    end
  end
  function automatic logic [31:0] ba(input logic [11:0] idx);
    return {18'h0, idx, 2'b00};  // byte address of a register index
  endfunction
  function automatic logic signed [11:0] sat12(input logic signed [13:0] v);
    return (v > 2047) ? 12'sh7FF : (v < -2048) ? 12'sh800 : v[11:0];
  endfunction
  function automatic logic signed [27:0] step(input logic signed [27:0] e, input logic signed [11:0] x);
    logic signed [29:0] d;
    d = $signed({x, 16'h0000}) - e;
    return e + (d >>> (bw + 9));
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      if (!ad && s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
      if (!wd && s_axi_wready) begin wd = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge ref_clk);  // gap so a following call never reassigns bready in this step
  endtask
  task automatic rdr(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge ref_clk);  // gap so a following call never reassigns rready in this step
  endtask
  // offers one sample for up to lim edges; models the correction at the take
  task automatic put(input logic [11:0] d, input logic [2:0] b, input logic cb, input logic ib, input int lim);
    logic signed [11:0] x, c;
    logic signed [27:0] t;
    logic on;
    x = d ^ 12'h800;
    if (cb && ib) x = sat12($signed({x[11], x}) + $signed({2'b00, trim[11:0]}) - 14'sd2048);
    on = filt && bw >= `BW_CODE_MIN && bw <= `BW_CODE_MAX;
    t = est[b] - glob;
    c = !on ? 12'sh000 : keep ? t[27:16] : est[b][27:16];
    sampleData <= d;
    sampleBank <= b;
    sampleCoreB <= cb;
    sampleInputB <= ib;
    sampleValid <= 1;
    do @(posedge ref_clk); while (sampleReady !== 1'b1 && --lim > 0);
    tk = sampleReady;
    if (tk) begin
      if (coreOnline) expq.push_back(sat12($signed({x[11], x}) - $signed({c[11], c})));
      if (on) begin est[b] = step(est[b], x); glob = step(glob, x); end
    end
  endtask
  task automatic burst(input int cnt, input logic [11:0] base);
    repeat (cnt) begin
      n = $urandom % 8;
      put(base + 12'(n * 16) + 12'($urandom % 8), 3'(n), $urandom, $urandom, 1000);
    end
    sampleValid <= 0;
    while (expq.size() != 0) @(posedge ref_clk);
  endtask
  initial begin
    n = $urandom(57139);
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, foregroundCalComplete, calHaltedFlag, coreCalibrated} = 0;
    {sampleData, sampleBank, sampleCoreB, sampleInputB, sampleValid, outReady, stall} = 0;
    {mismatches, checks_done, cycles, glob, bw, keep, filt} = 0;
    foreach (est[i]) est[i] = 0;
    s_axi_wstrb = 4'hF;
    factoryTrim = $urandom;
    trim = {4'h0, factoryTrim};
    rst = 1;
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    rdr(ba(`IDX_TRIM_B)); chk("trimReset", rd, {16'h0, trim});
    rdr(ba(`IDX_FILT_CTRL0)); chk("ctrl0Reset", rd, 32'h0000_0000);
    rdr(ba(`IDX_FILT_CTRL1)); chk("ctrl1Reset", rd, 32'h0000_0033);
    // random read-back, reserved bits included
    repeat (3) begin
      trim = $urandom;
      wr(ba(`IDX_TRIM_B), {16'h0, trim}); chk("wresp", rs, `RESP_OKAY);
      rdr(ba(`IDX_TRIM_B)); chk("trimBack", rd, {16'h0, trim});
      n = $urandom % 256;
      wr(ba(`IDX_FILT_CTRL0), n);
      rdr(ba(`IDX_FILT_CTRL0)); chk("ctrl0Back", rd, n);
    end
    wr(32'h0000_0300, 32'hFFFF_FFFF); chk("unmappedW", rs, `RESP_SLVERR);
    rdr(32'h0000_0252); chk("misalignedR", rs, `RESP_SLVERR);
    chk("misalignedD", rd, 0);
    for (int k = 0; k < 4; k++) begin
      foregroundCalComplete <= k[0];
      calHaltedFlag <= k[1];
      rdr(ba(`IDX_STATUS)); chk("status", rd[1:0], k[1:0]);
    end
    wr(ba(`IDX_FILT_CTRL0), 0);
    burst(50, 12'h400);
    // bandwidth codes 0-6, reserved 0 and 6 included, settle code kept equal
    for (int k = 0; k < 7; k++) begin
      bw = k;
      keep = k[0];
      filt = 1;
      wr(ba(`IDX_FILT_CTRL1), {24'h0, bw, bw});
      wr(ba(`IDX_FILT_CTRL0), keep);
      wr(ba(`IDX_CAL_CTRL), 32'h0000_0008);
      burst(90, 12'h7A0);
    end
    // fill the fifo until it refuses, then drain
    stall = 1;
    n = 0;
    tk = 1;
    while (tk && n < 60) begin
      put($urandom, $urandom, 0, 0, 3);
      n = n + tk;
    end
    sampleValid <= 0;
    chk("refused", tk, 0);
    chk("depthReached", n >= `FIFO_DEPTH, 1);
    stall = 0;
    while (expq.size() != 0) @(posedge ref_clk);
    // settle length per code, then enables that must not settle
    wr(ba(`IDX_CAL_CTRL), 32'h0000_000A);
    for (int s = 0; s < 4; s++) begin
      wr(ba(`IDX_FILT_CTRL1), 32'h10 + s);
      coreCalibrated <= 1;
      @(posedge ref_clk);
      coreCalibrated <= 0;
      n = 0;
      @(posedge ref_clk);
      while (coreOnline === 1'b0 && n < 2000) begin n++; @(posedge ref_clk); end
      chk("settleLen", n, UNIT << s);
    end
    rdr(ba(`IDX_STATUS)); chk("settleDone", rd[4], 1);
    wr(ba(`IDX_STATUS), 32'h10);
    rdr(ba(`IDX_STATUS)); chk("settleClear", rd[4], 0);
    foreach (est[i]) begin
      if (i < 2) begin
        wr(ba(`IDX_CAL_CTRL), i ? 32'h2 : 32'h8);
        coreCalibrated <= 1;
        @(posedge ref_clk);
        coreCalibrated <= 0;
        repeat (3) @(posedge ref_clk);
        chk("noSettle", coreOnline, 1);
      end
    end
    conclude();
  end
endmodule // adc_offset_trim_and_filter_tb
bind adc_offset_trim_and_filter adc_offset_trim_and_filter_properties #(.SETTLE_UNIT(SETTLE_UNIT)) chk (
  .ref_clk, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .coreCalibrated, .sampleReady, .outData,
  .outBank, .outValid, .outReady, .coreOnline);
`default_nettype wire
